// File: hdl/uld_buf2.sv
// Two-entry buffer with valid and ready on both sides
`default_nettype none
module uld_buf2 #(
  parameter int WIDTH = 8
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  input  wire logic             i_flush,
  input  wire logic             i_valid,
  output logic                  o_ready,
  input  wire logic [WIDTH-1:0] i_data,
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic      [WIDTH-1:0] o_data
);
  logic [WIDTH-1:0] mem_r [2];
  logic             wptr_r;
  logic             rptr_r;
  logic [1:0]       count_r;
  wire              push = i_valid && o_ready;
  wire              pop  = o_valid && i_ready;
  assign o_ready = (count_r != 2'd2);
  assign o_valid = (count_r != 2'd0);
  assign o_data  = mem_r[rptr_r];
  always_ff @(posedge i_clock) begin
    if (i_rst || i_flush) begin
      wptr_r  <= 1'b0;
      rptr_r  <= 1'b0;
      count_r <= 2'd0;
    end else begin
      if (push) begin
        wptr_r <= ~wptr_r;
      end
      if (pop) begin
        rptr_r <= ~rptr_r;
      end
      count_r <= count_r + {1'b0, push} - {1'b0, pop};
    end
  end
  always_ff @(posedge i_clock) begin
    if (push) begin
      mem_r[wptr_r] <= i_data;
    end
  end
endmodule
`default_nettype wire

// File: hdl/uld_defines.svh
// Constants for the serial unit: field positions, reset values, timing counts
`ifndef ULD_DEFINES_SVH
`define ULD_DEFINES_SVH
`define ULD_CLOCK_HZ        40000000
`define ULD_MAX_UART_BPS    625000
`define ULD_MIN_DIV         (`ULD_CLOCK_HZ / `ULD_MAX_UART_BPS)
`define ULD_SBL_BASE        13
`define ULD_SBF_MIN_BITS    11
`define ULD_ENABLE_SYNC     2
`define ULD_CONT_GAP        2
`define ULD_DALI_HZ         1200
`define ULD_DALI_TOL_PCT    10
`define ULD_RX_RESET        8'hff
`define ULD_TX_RESET        8'hff
`define ULD_RXDL_RESET      16'hffff
`define ULD_ROUTE_IRQ_BIT   0
`define ULD_ROUTE_CAP_BIT   1
`endif

// File: hdl/uld_pkg.sv
// Types shared by the serial unit
`default_nettype none
package uld_pkg;
  typedef enum logic [2:0] {
    ULD_TX_IDLE  = 3'b000,
    ULD_TX_START = 3'b001,
    ULD_TX_DATA  = 3'b010,
    ULD_TX_STOP  = 3'b011,
    ULD_TX_BREAK = 3'b100,
    ULD_TX_GAP   = 3'b101
  } uld_tx_state_t;
  typedef enum logic [1:0] {
    ULD_RX_IDLE  = 2'b00,
    ULD_RX_START = 2'b01,
    ULD_RX_DATA  = 2'b10,
    ULD_RX_STOP  = 2'b11
  } uld_rx_state_t;
endpackage
`default_nettype wire

// File: hdl/uld_serial.sv
// UART with LIN break support and DALI slave mode
`default_nettype none
`include "uld_defines.svh"
module uld_serial #(
  parameter int PRE_W = 4
) (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  // Control
  input  wire logic        i_unit_power_enable,
  input  wire logic        i_transmit_enable,
  input  wire logic        i_receive_enable,
  input  wire logic        i_protocol_mode_select,
  input  wire logic        i_char_len_8,
  input  wire logic        i_msb_first,
  input  wire logic        i_tx_invert,
  input  wire logic        i_break_rx_mode,
  input  wire logic [2:0]  i_break_length_field,
  input  wire logic [3:0]  i_base_clock_select,
  input  wire logic [7:0]  i_baud_divisor_control,
  input  wire logic [1:0]  i_input_route_bits,
  // Transmit data
  input  wire logic        i_tx_valid,
  output logic             o_tx_ready,
  input  wire logic [7:0]  i_transmit_buffer,
  input  wire logic        i_send_break,
  // Receive data
  output logic             o_rx_valid,
  output logic [7:0]       o_receive_buffer,
  output logic [15:0]      o_dali_receive,
  output logic             o_overrun_error_flag,
  output logic             o_framing_error_flag,
  output logic             o_parity_error_flag,
  output logic             o_break_received,
  output logic             o_break_error,
  // Events
  output logic             o_transmit_done_irq,
  output logic             o_receive_irq,
  // Pins
  input  wire logic        i_serial_in_pin,
  output logic             o_serial_out_pin,
  output logic             o_external_irq_zero,
  output logic             o_timer_capture_input
);
  // Enables and pin synchronised to the base clock
  logic txe_s, rxe_s, pwr_s, rxd_s;
  uld_sync2 u_sync_txe (.i_clock(i_clock), .i_rst(i_rst), .i_d(~i_transmit_enable),
    .i_init(1'b0), .o_q(txe_s));
  uld_sync2 u_sync_rxe (.i_clock(i_clock), .i_rst(i_rst), .i_d(~i_receive_enable),
    .i_init(1'b0), .o_q(rxe_s));
  uld_sync2 u_sync_pwr (.i_clock(i_clock), .i_rst(i_rst), .i_d(~i_unit_power_enable),
    .i_init(1'b0), .o_q(pwr_s));
  uld_sync2 u_sync_rxd (.i_clock(i_clock), .i_rst(i_rst), .i_d(i_serial_in_pin),
    .i_init(1'b0), .o_q(rxd_s));
  wire pwr_on = ~pwr_s;
  wire tx_on  = pwr_on && ~txe_s;
  wire rx_on  = pwr_on && ~rxe_s;
  wire dali   = i_protocol_mode_select;

  // Base clock prescaler and 8-bit baud generator
  logic [15:0] pre_r;
  logic [7:0]  brg_r;
  logic        tick_r;
  wire [15:0]  pre_lim = 16'((16'd1 << i_base_clock_select) - 16'd1);
  wire [7:0]   div_eff = (i_baud_divisor_control < 8'(`ULD_MIN_DIV))
                         ? 8'(`ULD_MIN_DIV) : i_baud_divisor_control;
  always_ff @(posedge i_clock) begin
    if (i_rst || !pwr_on) begin
      pre_r  <= 16'h0;
      brg_r  <= 8'h0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= 1'b0;
      if (pre_r >= pre_lim) begin
        pre_r <= 16'h0;
        if (brg_r >= div_eff - 8'h1) begin
          brg_r  <= 8'h0;
          tick_r <= 1'b1;
        end else begin
          brg_r <= brg_r + 8'h1;
        end
      end else begin
        pre_r <= pre_r + 16'h1;
      end
    end
  end
  // Half-bit ticks: the DALI transmitter uses two ticks per bit for Manchester halves
  logic [PRE_W-1:0] unused_pre;
  assign unused_pre = '0;

  // Transmit buffer
  logic       txq_valid, txq_pop;
  logic [7:0] txq_data;
  uld_buf2 #(.WIDTH(8)) u_txq (
    .i_clock(i_clock), .i_rst(i_rst), .i_flush(!tx_on),
    .i_valid(i_tx_valid), .o_ready(o_tx_ready), .i_data(i_transmit_buffer),
    .o_valid(txq_valid), .i_ready(txq_pop), .o_data(txq_data));

  // Transmitter
  uld_pkg::uld_tx_state_t tx_st_r;
  logic [15:0] tx_sh_r;
  logic [4:0]  tx_cnt_r;
  logic        tx_half_r;
  logic        tx_line_r;
  logic        tx_cont_r;
  logic        tx_irq_r;
  logic        pout_r;
  wire [4:0]   tx_nbits  = dali ? 5'd16 : (i_char_len_8 ? 5'd8 : 5'd7);
  wire [4:0]   brk_bits  = 5'(`ULD_SBL_BASE) + {2'b00, i_break_length_field};
  wire [7:0]   tx_rev    = {txq_data[0], txq_data[1], txq_data[2], txq_data[3],
                            txq_data[4], txq_data[5], txq_data[6], txq_data[7]};
  wire [7:0]   tx_ord    = i_msb_first ? (i_char_len_8 ? tx_rev : {tx_rev[6:0], 1'b0})
                                       : txq_data;
  wire         tx_bit    = dali ? tx_sh_r[15] : tx_sh_r[0];
  wire         man_bit   = tx_half_r ? tx_bit : ~tx_bit;
  assign txq_pop = tx_on && tick_r && (tx_st_r == uld_pkg::ULD_TX_IDLE) && !i_send_break;
  always_ff @(posedge i_clock) begin
    if (i_rst || !tx_on) begin
      tx_st_r   <= uld_pkg::ULD_TX_IDLE;
      tx_sh_r   <= {8'h00, 8'(`ULD_TX_RESET)};
      tx_cnt_r  <= 5'd0;
      tx_half_r <= 1'b0;
      tx_line_r <= 1'b1;
      tx_cont_r <= 1'b0;
      tx_irq_r  <= 1'b0;
    end else begin
      tx_irq_r <= 1'b0;
      if (tick_r) begin
        case (tx_st_r)
          uld_pkg::ULD_TX_IDLE: begin
            tx_line_r <= 1'b1;
            if (i_send_break && !dali) begin
              tx_st_r  <= uld_pkg::ULD_TX_BREAK;
              tx_cnt_r <= 5'd0;
            end else if (txq_valid) begin
              tx_sh_r  <= dali ? {txq_data, 8'h00} : {8'h00, tx_ord};
              tx_st_r  <= uld_pkg::ULD_TX_START;
              tx_cnt_r <= 5'd0;
            end
          end
          uld_pkg::ULD_TX_START: begin
            tx_line_r <= dali ? ~tx_half_r : 1'b0;
            tx_half_r <= dali ? ~tx_half_r : 1'b0;
            if (!dali || tx_half_r) begin
              tx_st_r <= uld_pkg::ULD_TX_DATA;
            end
          end
          uld_pkg::ULD_TX_DATA: begin
            tx_line_r <= dali ? man_bit : tx_bit;
            tx_half_r <= dali ? ~tx_half_r : 1'b0;
            if (!dali || tx_half_r) begin
              tx_sh_r  <= dali ? {tx_sh_r[14:0], 1'b0} : {1'b0, tx_sh_r[15:1]};
              tx_cnt_r <= tx_cnt_r + 5'd1;
              if (tx_cnt_r == tx_nbits - 5'd1) begin
                tx_st_r <= uld_pkg::ULD_TX_STOP;
              end
            end
          end
          uld_pkg::ULD_TX_STOP: begin
            tx_line_r <= 1'b1;
            tx_irq_r  <= 1'b1;
            tx_cont_r <= txq_valid;
            tx_cnt_r  <= 5'd0;
            tx_st_r   <= txq_valid ? uld_pkg::ULD_TX_GAP : uld_pkg::ULD_TX_IDLE;
          end
          uld_pkg::ULD_TX_BREAK: begin
            tx_line_r <= 1'b0;
            tx_cnt_r  <= tx_cnt_r + 5'd1;
            if (tx_cnt_r == brk_bits) begin
              tx_line_r <= 1'b1;
              tx_irq_r  <= 1'b1;
              tx_st_r   <= uld_pkg::ULD_TX_IDLE;
            end
          end
          default: begin
            tx_st_r <= uld_pkg::ULD_TX_IDLE;
          end
        endcase
      end else if (tx_st_r == uld_pkg::ULD_TX_GAP) begin
        tx_cnt_r <= tx_cnt_r + 5'd1;
        if (tx_cnt_r >= 5'(`ULD_CONT_GAP) - 5'd1) begin
          tx_st_r  <= uld_pkg::ULD_TX_IDLE;
          tx_cnt_r <= 5'd0;
        end
      end
    end
  end
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      pout_r              <= 1'b1;
      o_transmit_done_irq <= 1'b0;
    end else begin
      // Pin always from a flop, so a halted clock holds its level
      pout_r              <= tx_line_r ^ (i_tx_invert && !dali);
      o_transmit_done_irq <= tx_irq_r;
    end
  end
  assign o_serial_out_pin = pout_r;

  // Receiver
  uld_pkg::uld_rx_state_t rx_st_r;
  logic [15:0] rx_sh_r;
  logic [4:0]  rx_cnt_r;
  logic        rx_low_r;
  logic [4:0]  rx_low_cnt_r;
  logic        rxd_d_r;
  wire [4:0]   rx_nbits = dali ? 5'd16 : (i_char_len_8 ? 5'd8 : 5'd7);
  wire         brk_mode = i_break_rx_mode && !dali;
  wire [7:0]   rx_byte  = i_char_len_8 ? rx_sh_r[15:8] : {1'b0, rx_sh_r[15:9]};
  wire [7:0]   rx_msb   = {rx_sh_r[8], rx_sh_r[9], rx_sh_r[10], rx_sh_r[11],
                           rx_sh_r[12], rx_sh_r[13], rx_sh_r[14], rx_sh_r[15]};
  wire [7:0]   rx_out   = i_msb_first ? (i_char_len_8 ? rx_msb : {rx_msb[7:1], 1'b0})
                                      : rx_byte;
  always_ff @(posedge i_clock) begin
    if (i_rst || !rx_on) begin
      rx_st_r              <= uld_pkg::ULD_RX_IDLE;
      rx_sh_r              <= {8'hff, 8'(`ULD_RX_RESET)};
      rx_cnt_r             <= 5'd0;
      rx_low_cnt_r         <= 5'd0;
      rx_low_r             <= 1'b0;
      rxd_d_r              <= 1'b1;
      o_rx_valid           <= 1'b0;
      o_receive_irq        <= 1'b0;
      o_break_received     <= 1'b0;
      o_break_error        <= 1'b0;
      o_overrun_error_flag <= 1'b0;
      o_framing_error_flag <= 1'b0;
      o_parity_error_flag  <= 1'b0;
      o_receive_buffer     <= `ULD_RX_RESET;
      o_dali_receive       <= `ULD_RXDL_RESET;
    end else begin
      rxd_d_r       <= rxd_s;
      o_rx_valid    <= 1'b0;
      o_receive_irq <= 1'b0;
      o_break_error <= 1'b0;
      if (tick_r) begin
        case (rx_st_r)
          uld_pkg::ULD_RX_IDLE: begin
            if (!rxd_s) begin
              rx_st_r      <= uld_pkg::ULD_RX_DATA;
              rx_cnt_r     <= 5'd0;
              rx_low_cnt_r <= 5'd1;
              rx_low_r     <= 1'b1;
            end
          end
          uld_pkg::ULD_RX_DATA: begin
            if (rx_low_r && !rxd_s && rx_low_cnt_r != 5'h1f) begin
              rx_low_cnt_r <= rx_low_cnt_r + 5'd1;
            end else begin
              rx_low_r <= 1'b0;
            end
            if (!brk_mode) begin
              rx_sh_r <= dali ? {rx_sh_r[14:0], rxd_s} : {rxd_s, rx_sh_r[15:1]};
            end
            rx_cnt_r <= rx_cnt_r + 5'd1;
            if (brk_mode ? rxd_s && !rx_low_r : rx_cnt_r == rx_nbits - 5'd1) begin
              rx_st_r <= uld_pkg::ULD_RX_STOP;
            end
          end
          uld_pkg::ULD_RX_STOP: begin
            rx_st_r <= uld_pkg::ULD_RX_IDLE;
            if (brk_mode) begin
              if (rx_low_cnt_r >= 5'(`ULD_SBF_MIN_BITS)) begin
                o_break_received <= 1'b1;
                o_receive_irq    <= 1'b1;
              end else begin
                o_break_error <= 1'b1;
              end
            end else if (dali) begin
              o_dali_receive <= rx_sh_r;
              o_rx_valid     <= 1'b1;
              o_receive_irq  <= 1'b1;
            end else begin
              o_framing_error_flag <= !rxd_s;
              o_overrun_error_flag <= o_rx_valid;
              o_parity_error_flag  <= 1'b0;
              o_receive_buffer     <= rx_out;
              o_rx_valid           <= 1'b1;
              o_receive_irq        <= 1'b1;
            end
          end
          default: begin
            rx_st_r <= uld_pkg::ULD_RX_IDLE;
          end
        endcase
      end
    end
  end

  // Internal routing of receive input
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_external_irq_zero   <= 1'b1;
      o_timer_capture_input <= 1'b1;
    end else begin
      o_external_irq_zero   <= i_input_route_bits[`ULD_ROUTE_IRQ_BIT] ? rxd_s : 1'b1;
      o_timer_capture_input <= i_input_route_bits[`ULD_ROUTE_CAP_BIT] ? rxd_s : 1'b1;
    end
  end
  logic unused_rxd;
  assign unused_rxd = rxd_d_r;
endmodule
`default_nettype wire

// File: hdl/uld_sync2.sv
// Two-flop synchroniser for a single level
`default_nettype none
module uld_sync2 (
  input  wire logic i_clock,
  input  wire logic i_rst,
  input  wire logic i_d,
  input  wire logic i_init,
  output logic      o_q
);
  logic meta_r;
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      meta_r <= 1'b1;
      o_q    <= 1'b1;
    end else begin
      meta_r <= i_d;
      o_q    <= meta_r;
    end
  end
  logic unused_init;
  assign unused_init = i_init;
endmodule
`default_nettype wire

// File: tb/uld_lin_partner.sv
// LIN transceiver model facing the serial unit's pins
`default_nettype none
module uld_lin_partner #(
  parameter int BIT = 64
) (
  input  wire logic i_clock,
  input  wire logic i_line,
  input  wire logic i_inv,
  output logic      o_line
);
  logic       line;
  logic [7:0] got;
  int         got_n;
  int         run;
  int         last_low;
  assign line = i_line ^ i_inv;
  initial begin
    o_line = 1'h1;
    got = 8'h00;
    got_n = 0;
    run = 0;
    last_low = 0;
  end
  // Frame receiver, LSB first, start confirmed at mid-bit
  initial forever begin
    @(negedge line);
    repeat (BIT / 2) @(posedge i_clock);
    if (!line) begin
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge i_clock);
        got[i] = line;
      end
      repeat (BIT) @(posedge i_clock);
      got_n++;
    end
  end
  // Length of the last low stretch in clocks
  always @(posedge i_clock) begin
    if (!line) begin
      run <= run + 1;
    end else if (run != 0) begin
      last_low <= run;
      run <= 0;
    end
  end
  // Bits LSB first, one bit time each, then the pull-up level
  task automatic send(input logic [31:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      o_line = b[i];
      repeat (BIT) @(negedge i_clock);
    end
    o_line = 1'h1;
    repeat (BIT) @(negedge i_clock);
  endtask
endmodule
`default_nettype wire

// File: tb/uld_serial_props.sv
// Checker of the serial unit's port behaviour
`default_nettype none
module uld_serial_props (
  // Clock, reset and controls
  input wire logic        i_clock,
  input wire logic        i_rst,
  input wire logic        i_unit_power_enable,
  input wire logic        i_transmit_enable,
  input wire logic        i_tx_invert,
  input wire logic        i_break_rx_mode,
  input wire logic        i_send_break,
  input wire logic [1:0]  i_input_route_bits,
  // Pins and results
  input wire logic        i_serial_in_pin,
  input wire logic        o_serial_out_pin,
  input wire logic        o_rx_valid,
  input wire logic [7:0]  o_receive_buffer,
  input wire logic [15:0] o_dali_receive,
  input wire logic        o_break_received,
  input wire logic        o_break_error,
  input wire logic        o_transmit_done_irq,
  input wire logic        o_receive_irq,
  input wire logic        o_external_irq_zero,
  input wire logic        o_timer_capture_input
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);

  rst_idle_a: assert property ($fell(i_rst) && !i_tx_invert |-> o_serial_out_pin
    && !o_transmit_done_irq && !o_receive_irq) else $error("pin or events wrong after reset");
  rst_bufs_a: assert property ($fell(i_rst) |-> o_receive_buffer == 8'hff
    && o_dali_receive == 16'hffff) else $error("receive buffers not all ones");
  stop_idle_a: assert property ((!i_tx_invert && !i_send_break
    && !(i_unit_power_enable && i_transmit_enable))[*6] |-> o_serial_out_pin)
    else $error("pin not idle while transmit is off");
  route_irq_a: assert property ((i_input_route_bits[0] && $stable(i_serial_in_pin))[*5]
    |-> o_external_irq_zero == i_serial_in_pin) else $error("irq route not following pin");
  route_cap_a: assert property ((!i_input_route_bits[1])[*3] |-> o_timer_capture_input)
    else $error("capture route not high when off");
  break_quiet_a: assert property (i_break_rx_mode[*4] |-> !o_rx_valid)
    else $error("data transferred in break mode");
  break_err_a: assert property (o_break_error |-> !o_receive_irq && !o_rx_valid)
    else $error("short low raised an event");
  break_irq_a: assert property (o_receive_irq && i_break_rx_mode |-> ##[0:2] o_break_received)
    else $error("break interrupt without flag");
  done_stop_a: assert property (o_transmit_done_irq && !i_tx_invert |-> o_serial_out_pin)
    else $error("transmit done before stop level");

  tx_done_c: cover property (o_transmit_done_irq);
  rx_data_c: cover property (o_rx_valid);
  brk_rx_c: cover property ($rose(o_break_received));
endmodule
`default_nettype wire

// File: tb/uld_serial_tb.sv
// Testbench of the serial unit with a LIN partner model
`default_nettype none
module uld_serial_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BIT = 64;
  logic        clk, rst, pwr, txe, rxe, mode, len8, msb, inv, brx, sbrk, tx_valid, p_inv;
  logic [2:0]  blen;
  logic [1:0]  route;
  logic [7:0]  tx_data, rx_buf;
  logic [15:0] dali;
  logic        tx_ready, rx_valid, brk_rx, brk_err, tx_irq, rx_irq, pin_in, pin_out, ext_irq, cap;
  logic        fe, ove;
  logic [4:0]  ev;
  int          errors, compares, rxn, nrx, t0, gap;
  assign ev = {~pin_out, brk_rx, brk_err, tx_irq, rx_valid};
  always @(posedge clk) begin
    if (rst) begin
      rxn <= 0;
    end else if (rx_valid === 1'h1) begin
      rxn <= rxn + 1;
    end
  end

  uld_serial dut_u (.i_clock(clk), .i_rst(rst), .i_unit_power_enable(pwr),
    .i_transmit_enable(txe), .i_receive_enable(rxe), .i_protocol_mode_select(mode),
    .i_char_len_8(len8), .i_msb_first(msb), .i_tx_invert(inv), .i_break_rx_mode(brx),
    .i_break_length_field(blen), .i_base_clock_select(4'h0), .i_baud_divisor_control(8'h40),
    .i_input_route_bits(route), .i_tx_valid(tx_valid), .o_tx_ready(tx_ready),
    .i_transmit_buffer(tx_data), .i_send_break(sbrk), .o_rx_valid(rx_valid),
    .o_receive_buffer(rx_buf), .o_dali_receive(dali), .o_overrun_error_flag(ove),
    .o_framing_error_flag(fe), .o_parity_error_flag(), .o_break_received(brk_rx),
    .o_break_error(brk_err), .o_transmit_done_irq(tx_irq), .o_receive_irq(rx_irq),
    .i_serial_in_pin(pin_in), .o_serial_out_pin(pin_out), .o_external_irq_zero(ext_irq),
    .o_timer_capture_input(cap));
  uld_lin_partner #(.BIT(BIT)) p_u (.i_clock(clk), .i_line(pin_out), .i_inv(p_inv),
    .o_line(pin_in));

  task automatic close_out();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    compares++;
    if (ok !== 1'h1) begin
      errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic wait_ev(input int k, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (ev[k] !== 1'h1 && n < lim);
    if (ev[k] !== 1'h1) begin
      check(1'h0, "event timeout");
      close_out();
    end
  endtask
  task automatic put(input logic [7:0] d);
    int n;
    n = 0;
    @(negedge clk);
    tx_valid = 1'h1;
    tx_data = d;
    while (tx_ready !== 1'h1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    check(n < 100, "byte refused");
    // Ready seen high here holds to the next rising edge, which takes the byte
    @(negedge clk);
    tx_valid = 1'h0;
  endtask
  task automatic send_chk(input logic [7:0] d, input logic [7:0] exp);
    put(d);
    wait_ev(1, 2000);
    repeat (BIT) @(negedge clk);
    check(p_u.got === exp, "byte on the line");
  endtask

  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    {pwr, txe, rxe, mode, msb, inv, brx, sbrk, tx_valid, p_inv} = '0;
    rst = 1'h1;
    len8 = 1'h1;
    blen = 3'h0;
    route = 2'h0;
    tx_data = 8'h00;
    {errors, compares} = '0;
    repeat (12) @(negedge clk);
    rst = 1'h0;
    @(negedge clk);
    check(pin_out === 1'h1 && tx_ready === 1'h1 && rx_buf === 8'hff, "reset state");
    check(dali === 16'hffff && ext_irq === 1'h1 && cap === 1'h1, "reset outputs");
    pwr = 1'h1;
    repeat (3) @(negedge clk);
    txe = 1'h1;
    rxe = 1'h1;
    repeat (4) @(negedge clk);
    send_chk(8'ha5, 8'ha5);
    msb = 1'h1;
    send_chk(8'h80, 8'h01);
    msb = 1'h0;
    put(8'h3c);
    put(8'hc3);
    wait_ev(1, 2000);
    t0 = int'($time);
    wait_ev(1, 2000);
    gap = (int'($time) - t0) / 25;
    check(gap >= 10 * BIT + 2 && gap <= 11 * BIT + 8, "back to back spacing");
    check(p_u.got === 8'hc3, "second byte");
    for (int f = 0; f < 8; f += 7) begin
      blen = f[2:0];
      sbrk = 1'h1;
      wait_ev(4, 2000);
      sbrk = 1'h0;
      wait_ev(1, 4000);
      repeat (4) @(negedge clk);
      check(p_u.last_low >= (13 + f) * BIT - 3 && p_u.last_low <= (13 + f) * BIT + 3,
        "break length");
    end
    inv = 1'h1;
    p_inv = 1'h1;
    repeat (4) @(negedge clk);
    fork
      p_u.send({22'h0, 1'h1, 8'h96, 1'h0}, 10);
      begin
        wait_ev(0, 2000);
        check(rx_buf === 8'h96, "receive beside inverted send");
      end
      send_chk(8'h5a, 8'h5a);
    join
    inv = 1'h0;
    p_inv = 1'h0;
    len8 = 1'h0;
    repeat (4) @(negedge clk);
    fork
      p_u.send({23'h0, 1'h1, 7'h2a, 1'h0}, 9);
      wait_ev(0, 2000);
    join
    check(rx_buf === 8'h2a, "seven bit byte");
    check(fe === 1'h0 && ove === 1'h0, "receive error flags");
    len8 = 1'h1;
    route = 2'h3;
    brx = 1'h1;
    nrx = rxn;
    repeat (4) @(negedge clk);
    fork
      p_u.send(32'h0, 8);
      wait_ev(2, 2000);
    join
    check(brk_rx === 1'h0, "short low taken as break");
    fork
      p_u.send(32'h0, 12);
      begin
        repeat (BIT * 6) @(negedge clk);
        check(ext_irq === 1'h0 && cap === 1'h0, "route follows pin");
      end
      wait_ev(3, 2000);
    join
    check(rx_buf === 8'h2a && rxn === nrx, "transfer during break mode");
    {pwr, txe, rxe, brx} = '0;
    repeat (4) @(negedge clk);
    check(pin_out === 1'h1 && rx_buf === 8'hff && brk_rx === 1'h0, "enables cleared");
    mode = 1'h1;
    pwr = 1'h1;
    repeat (3) @(negedge clk);
    txe = 1'h1;
    repeat (4) @(negedge clk);
    put(8'hc5);
    wait_ev(1, 4000);
    repeat (2) @(negedge clk);
    check(p_u.last_low >= BIT - 3 && p_u.last_low <= 2 * BIT + 3, "half bit lows");
    close_out();
  end
endmodule
bind uld_serial uld_serial_props chk_u (.i_clock, .i_rst, .i_unit_power_enable,
  .i_transmit_enable, .i_tx_invert, .i_break_rx_mode, .i_send_break, .i_input_route_bits,
  .i_serial_in_pin, .o_serial_out_pin, .o_rx_valid, .o_receive_buffer, .o_dali_receive,
  .o_break_received, .o_break_error, .o_transmit_done_irq, .o_receive_irq,
  .o_external_irq_zero, .o_timer_capture_input);
`default_nettype wire
